// [src/rrc_pkg.sv]
// Package: constants shared by the rotate/round/set-carry execution block
package rrc_pkg;
   localparam int ACC_W = 24;
   localparam int CNT_W = 4;
   localparam logic [1:0] SEL_X = 2'h0;
   localparam logic [1:0] SEL_Y = 2'h1;
   localparam logic [1:0] SEL_Z = 2'h2;
   localparam logic [1:0] SEL_R = 2'h3;
   // Op codes on the issue port
   localparam logic [1:0] OP_NONE = 2'h0;
   localparam logic [1:0] OP_ROTATE_RIGHT_CARRY_OP = 2'h1;
   localparam logic [1:0] OP_ROUND = 2'h2;
   localparam logic [1:0] OP_FORCE_CARRY_OP = 2'h3;
   // Instruction lengths in bytes
   localparam logic [2:0] LEN_ROTATE_RIGHT_CARRY_OP_SHORT = 3'h1;
   localparam logic [2:0] LEN_ROTATE_RIGHT_CARRY_OP_LONG = 3'h2;
   localparam logic [2:0] LEN_ROUND = 3'h7;
   localparam logic [2:0] LEN_FORCE_CARRY_OP = 3'h1;
   // Rounding threshold digit
   localparam int ROUND_HALF = 5;
   // AHB register map
   localparam logic [7:0] ADDR_ACC_X = 8'h00;
   localparam logic [7:0] ADDR_ACC_Y = 8'h04;
   localparam logic [7:0] ADDR_ACC_Z = 8'h08;
   localparam logic [7:0] ADDR_ACC_R = 8'h0C;
   localparam logic [7:0] ADDR_FLAGS = 8'h10;
   localparam logic [7:0] ADDR_CMD = 8'h14;
   localparam logic [7:0] ADDR_STAT = 8'h18;
   localparam logic [7:0] ADDR_DIV = 8'h1C;
   // Flag register bits
   localparam int FLG_C = 0;
   localparam int FLG_O = 1;
   localparam int FLG_S = 2;
   localparam int FLG_Z = 3;
   // Command register fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_SEL_LSB = 2;
   localparam int CMD_HASCNT = 4;
   localparam int CMD_CNT_LSB = 8;
   localparam logic [ACC_W-1:0] ACC_RST = 24'h000000;
   localparam logic [3:0] FLAGS_RST = 4'h0;
   localparam logic [ACC_W-1:0] DIV_RST = 24'h00000A;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ROT = 3'b010,
      ST_RND = 3'b100
   } rrc_state_t;
endpackage

// [src/rrc_rot_step.sv]
// One rotate-right-through-carry step with its flag results
`timescale 1ns/1ps
module rrc_rot_step #(
   parameter int W = 24
) (
   // Operand in
   input wire logic [W-1:0] val_in,
   input wire logic carry_in,
   // Result out
   output logic [W-1:0] val_out,
   output logic carry_out,
   output logic ovf_out,
   output logic sign_out,
   output logic zero_out
);
   assign val_out = {carry_in, val_in[W-1:1]};
   assign carry_out = val_in[0];
   // Sign change across the step counts as overflow
   assign ovf_out = val_in[W-1] ^ carry_in;
   assign sign_out = carry_in;
   assign zero_out = ({carry_in, val_in[W-1:1]} == '0);
endmodule

// [src/rrc_core.sv]
// Rotate-right, rounding and set-carry execution with an AHB-Lite register slave
`timescale 1ns/1ps
module rrc_core #(
   parameter int ACC_W = rrc_pkg::ACC_W,
   parameter int CNT_W = rrc_pkg::CNT_W
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Status
   output logic busy,
   output logic [2:0] instr_len
);
   rrc_pkg::rrc_state_t state_r, state_nxt;
   logic [ACC_W-1:0] acc_r [4];
   logic [3:0] flags_r;
   logic [ACC_W-1:0] div_r;
   logic [CNT_W-1:0] cnt_r;
   logic [1:0] sel_r;
   logic [2:0] len_r;
   logic [31:0] cycles_r;
   logic [ACC_W-1:0] quot_r, rem_r;
   logic done_r;
   // Address phase capture
   logic wr_pend_r, rd_pend_r;
   logic [7:0] addr_r;
   wire addr_ok = hsel && hready && htrans[1];
   wire [7:0] a_lo = {haddr[7:2], 2'b00};
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r <= 8'h00;
      end else begin
         wr_pend_r <= addr_ok && hwrite;
         rd_pend_r <= addr_ok && !hwrite;
         if (addr_ok) begin
            addr_r <= a_lo;
         end
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   // Command decode from data phase
   wire cmd_wr = wr_pend_r && (addr_r == rrc_pkg::ADDR_CMD) && (state_r == rrc_pkg::ST_IDLE);
   wire [1:0] cmd_op = hwdata[rrc_pkg::CMD_OP_LSB +: 2];
   wire [1:0] cmd_sel = hwdata[rrc_pkg::CMD_SEL_LSB +: 2];
   wire cmd_hascnt = hwdata[rrc_pkg::CMD_HASCNT];
   wire [CNT_W-1:0] cmd_cnt = hwdata[rrc_pkg::CMD_CNT_LSB +: CNT_W];
   wire acc_wr = wr_pend_r && (addr_r[7:4] == 4'h0) && (state_r == rrc_pkg::ST_IDLE);
   wire flg_wr = wr_pend_r && (addr_r == rrc_pkg::ADDR_FLAGS) && (state_r == rrc_pkg::ST_IDLE);
   wire div_wr = wr_pend_r && (addr_r == rrc_pkg::ADDR_DIV) && (state_r == rrc_pkg::ST_IDLE);
   // Rotate datapath on selected accumulator
   wire [1:0] rot_sel = (state_r == rrc_pkg::ST_IDLE) ? cmd_sel : sel_r;
   wire [ACC_W-1:0] rot_out;
   wire rot_c, rot_o, rot_s, rot_z;
   rrc_rot_step #(.W(ACC_W)) u_step (
      .val_in(acc_r[rot_sel]),
      .carry_in(flags_r[rrc_pkg::FLG_C]),
      .val_out(rot_out),
      .carry_out(rot_c),
      .ovf_out(rot_o),
      .sign_out(rot_s),
      .zero_out(rot_z)
   );
   // Rotate without count executes immediately in the issue cycle
   wire rot_now = cmd_wr && (cmd_op == rrc_pkg::OP_ROTATE_RIGHT_CARRY_OP) && !cmd_hascnt;
   wire rot_go = cmd_wr && (cmd_op == rrc_pkg::OP_ROTATE_RIGHT_CARRY_OP) && cmd_hascnt;
   wire rot_step = (state_r == rrc_pkg::ST_ROT) && (cnt_r != '0);
   wire force_carry_op_now = cmd_wr && (cmd_op == rrc_pkg::OP_FORCE_CARRY_OP);
   wire rnd_go = cmd_wr && (cmd_op == rrc_pkg::OP_ROUND);
   // Rounding: quotient of x by the scale division, remainder scaled to a digit
   wire [ACC_W+3:0] rem_x10 = {4'h0, rem_r} * 28'd10;
   wire [ACC_W+3:0] div_ext = {4'h0, div_r};
   wire round_up = (rem_x10 >= div_ext * 28'(rrc_pkg::ROUND_HALF));
   wire rnd_busy = (rem_r >= div_r) && (div_r != '0);
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         rrc_pkg::ST_IDLE: begin
            if (rot_go) begin
               state_nxt = rrc_pkg::ST_ROT;
            end else if (rnd_go) begin
               state_nxt = rrc_pkg::ST_RND;
            end
         end
         rrc_pkg::ST_ROT: begin
            if (cnt_r == '0) begin
               state_nxt = rrc_pkg::ST_IDLE;
            end
         end
         rrc_pkg::ST_RND: begin
            if (!rnd_busy) begin
               state_nxt = rrc_pkg::ST_IDLE;
            end
         end
         default: state_nxt = rrc_pkg::ST_IDLE;
      endcase
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= rrc_pkg::ST_IDLE;
         cnt_r <= '0;
         sel_r <= rrc_pkg::SEL_X;
         len_r <= 3'h0;
         quot_r <= '0;
         rem_r <= '0;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         done_r <= (state_r == rrc_pkg::ST_RND) && !rnd_busy;
         if (rot_step) begin
            cnt_r <= cnt_r - 1'b1;
         end
         if (cmd_wr) begin
            sel_r <= cmd_sel;
            cnt_r <= cmd_cnt;
         end
         if (rot_now) begin
            len_r <= rrc_pkg::LEN_ROTATE_RIGHT_CARRY_OP_SHORT;
         end else if (rot_go) begin
            len_r <= rrc_pkg::LEN_ROTATE_RIGHT_CARRY_OP_LONG;
         end else if (rnd_go) begin
            len_r <= rrc_pkg::LEN_ROUND;
         end else if (force_carry_op_now) begin
            len_r <= rrc_pkg::LEN_FORCE_CARRY_OP;
         end
         if (rnd_go) begin
            quot_r <= '0;
            rem_r <= acc_r[rrc_pkg::SEL_X];
         end else if (rnd_busy && state_r == rrc_pkg::ST_RND) begin
            quot_r <= quot_r + 1'b1;
            rem_r <= rem_r - div_r;
         end
      end
   end
   // Accumulators and flags; a rotate writes only the selected accumulator, a round always writes x
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            acc_r[i] <= rrc_pkg::ACC_RST;
         end
         flags_r <= rrc_pkg::FLAGS_RST;
         div_r <= rrc_pkg::DIV_RST;
      end else begin
         if (acc_wr) begin
            acc_r[addr_r[3:2]] <= hwdata[ACC_W-1:0];
         end
         if (div_wr) begin
            div_r <= hwdata[ACC_W-1:0];
         end
         if (flg_wr) begin
            flags_r <= hwdata[3:0];
         end
         if (rot_now || rot_step) begin
            acc_r[rot_sel] <= rot_out;
            flags_r <= {rot_z, rot_s, rot_o, rot_c};
         end
         if (force_carry_op_now) begin
            flags_r[rrc_pkg::FLG_C] <= 1'b1;
            flags_r[rrc_pkg::FLG_O] <= 1'b0;
         end
         if ((state_r == rrc_pkg::ST_RND) && !rnd_busy) begin
            acc_r[rrc_pkg::SEL_X] <= round_up ? ACC_W'(quot_r + 1'b1) : quot_r;
         end
      end
   end
   // Cycle counter of the current instruction, for software timing
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cycles_r <= 32'h00000000;
      end else if (cmd_wr) begin
         cycles_r <= 32'h00000001;
      end else if (state_r != rrc_pkg::ST_IDLE && state_nxt != rrc_pkg::ST_IDLE) begin
         cycles_r <= cycles_r + 32'h00000001;
      end
   end
   assign busy = (state_r != rrc_pkg::ST_IDLE);
   assign instr_len = len_r;
   // Read data, driven combinationally from the registers in the data phase
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h00000000;
      unique case (addr_r)
         rrc_pkg::ADDR_ACC_X, rrc_pkg::ADDR_ACC_Y, rrc_pkg::ADDR_ACC_Z, rrc_pkg::ADDR_ACC_R:
            rd_mux = {{(32-ACC_W){1'b0}}, acc_r[addr_r[3:2]]};
         rrc_pkg::ADDR_FLAGS: rd_mux = {28'h0000000, flags_r};
         rrc_pkg::ADDR_STAT: rd_mux = {cycles_r[23:0], 3'h0, done_r, busy, len_r};
         rrc_pkg::ADDR_DIV: rd_mux = {{(32-ACC_W){1'b0}}, div_r};
         default: rd_mux = 32'h00000000;
      endcase
   end
   assign hrdata = rd_pend_r ? rd_mux : 32'h00000000;
   // Assertions
   AST_ROT_LSB_TO_C: assert property (@(posedge mclk) disable iff (!rst_n)
      rot_now |=> flags_r[rrc_pkg::FLG_C] == $past(acc_r[rot_sel][0]))
      else $error("carry not loaded from old lsb");
   AST_ROT_MSB_FROM_C: assert property (@(posedge mclk) disable iff (!rst_n)
      rot_now |=> acc_r[sel_r][ACC_W-1] == $past(flags_r[rrc_pkg::FLG_C]))
      else $error("msb not loaded from old carry");
   AST_ROT_REPEAT: assert property (@(posedge mclk) disable iff (!rst_n)
      rot_step |=> cnt_r == $past(cnt_r) - 1'b1)
      else $error("repeat count not stepping");
   AST_ROT_CNT_TIME: assert property (@(posedge mclk) disable iff (!rst_n)
      (rot_go && cmd_cnt == 4'h3) |=> busy [*4] ##1 !busy)
      else $error("rotate with count took wrong cycles");
   AST_ROT_ZERO_CNT: assert property (@(posedge mclk) disable iff (!rst_n)
      (rot_go && cmd_cnt == 4'h0) |=> busy ##1 !busy)
      else $error("zero count not one cycle");
   AST_ROT_LEN: assert property (@(posedge mclk) disable iff (!rst_n)
      rot_go |=> instr_len == rrc_pkg::LEN_ROTATE_RIGHT_CARRY_OP_LONG)
      else $error("rotate length wrong");
   AST_FORCE_CARRY_OP: assert property (@(posedge mclk) disable iff (!rst_n)
      force_carry_op_now |=> flags_r[1:0] == 2'b01 && !busy && flags_r[3:2] == $past(flags_r[3:2]))
      else $error("set carry wrong");
   AST_ROUND_LEN: assert property (@(posedge mclk) disable iff (!rst_n)
      rnd_go |=> busy && instr_len == rrc_pkg::LEN_ROUND)
      else $error("round not started");
   AST_ROT_FLAG_Z: assert property (@(posedge mclk) disable iff (!rst_n)
      rot_now |=> flags_r[rrc_pkg::FLG_Z] == (acc_r[sel_r] == '0))
      else $error("zero flag mismatch");
   AST_OTHER_ACC: assert property (@(posedge mclk) disable iff (!rst_n)
      (rot_now && cmd_sel != rrc_pkg::SEL_X) |=> acc_r[rrc_pkg::SEL_X] == $past(acc_r[rrc_pkg::SEL_X]))
      else $error("unselected accumulator changed");
endmodule

// [dv/rrc_core_bench.sv]
// Self-checking bench for the rotate, round and set-carry block over AHB-Lite
`timescale 1ns/1ps
module rrc_core_bench;
   typedef struct {logic [1:0] sel; logic hc; logic [3:0] cnt; logic [23:0] val; logic [3:0] flg;} rrc_row_t;
   logic mclk, rst_n, hsel, hwrite, hready, hreadyout, hresp, busy;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize, instr_len;
   logic [23:0] acc_exp [4];
   logic [27:0] m;
   int mismatches = 0;
   int samples_checked = 0;
   int n;
   rrc_row_t rows [6] = '{'{2'h0, 1'b0, 4'h0, 24'h000001, 4'h0}, '{2'h1, 1'b0, 4'h0, 24'h000002, 4'h1},
      '{2'h2, 1'b1, 4'hF, 24'hA5A5A5, 4'h0}, '{2'h3, 1'b1, 4'h3, 24'h800000, 4'h1},
      '{2'h0, 1'b1, 4'h0, 24'h123456, 4'h5}, '{2'h1, 1'b1, 4'h1, 24'h000000, 4'h0}};
   // Single slave, so its ready is the bus ready
   assign hready = hreadyout;
   rrc_core dut_u (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .busy(busy), .instr_len(instr_len));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic tally_and_finish;
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      tally_and_finish;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: %0s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      hsize <= 3'h2;
      htrans <= 2'h2;
      do @(posedge mclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge mclk); while (hready !== 1'b1);
      rd = hrdata;
      chk({31'h0, hresp}, 32'h0, "hresp");
      chk({31'h0, hreadyout}, 32'h1, "hreadyout");
   endtask
   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp, what);
   endtask
   // Counts cycles of busy after the command edge; a bound keeps a stuck busy from hanging here
   task automatic wait_idle;
      #1;
      n = 0;
      while (busy === 1'b1 && n < 400) begin
         @(posedge mclk);
         #1;
         n++;
      end
   endtask
   function automatic logic [31:0] cmd(input logic [1:0] op, input logic [1:0] sel, input logic hc,
         input logic [3:0] cnt);
      return {20'h0, cnt, 3'h0, hc, sel, op};
   endfunction
   // Returns {Z,S,O,C, value} after k steps through carry
   function automatic logic [27:0] rot_model(input logic [23:0] v, input logic [3:0] f, input int k);
      logic [23:0] nv;
      for (int i = 0; i < k; i++) begin
         nv = {f[0], v[23:1]};
         f = {nv == 24'h0, f[0], v[23] ^ f[0], v[0]};
         v = nv;
      end
      return {f, v};
   endfunction
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      rst_n = 1'b0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         acc_exp[k] = 24'h0;
         rd_chk({4'h0, 2'(k), 2'h0}, 32'h0, "acc reset");
      end
      rd_chk(rrc_pkg::ADDR_FLAGS, 32'h0, "flags reset");
      rd_chk(rrc_pkg::ADDR_DIV, 32'h0000000A, "div reset");
      chk({29'h0, instr_len}, 32'h0, "len reset");
      $display("test reset done");
      foreach (rows[i]) begin
         wr32({4'h0, rows[i].sel, 2'h0}, {8'h00, rows[i].val});
         wr32(rrc_pkg::ADDR_FLAGS, {28'h0, rows[i].flg});
         wr32(rrc_pkg::ADDR_CMD, cmd(rrc_pkg::OP_ROTATE_RIGHT_CARRY_OP, rows[i].sel, rows[i].hc, rows[i].cnt));
         wait_idle;
         chk(n, rows[i].hc ? rows[i].cnt + 1 : 0, "busy cycles");
         m = rot_model(rows[i].val, rows[i].flg, rows[i].hc ? int'(rows[i].cnt) : 1);
         acc_exp[rows[i].sel] = m[23:0];
         for (int k = 0; k < 4; k++) begin
            rd_chk({4'h0, 2'(k), 2'h0}, {8'h00, acc_exp[k]}, "acc");
         end
         rd_chk(rrc_pkg::ADDR_FLAGS, {28'h0, m[27:24]}, "flags");
         chk(instr_len, rows[i].hc ? rrc_pkg::LEN_ROTATE_RIGHT_CARRY_OP_LONG : rrc_pkg::LEN_ROTATE_RIGHT_CARRY_OP_SHORT, "len");
      end
      $display("test rotate rows done");
      wr32(rrc_pkg::ADDR_FLAGS, 32'h0);
      wr32(rrc_pkg::ADDR_ACC_X, 32'h00000F0F);
      wr32(rrc_pkg::ADDR_CMD, cmd(rrc_pkg::OP_ROTATE_RIGHT_CARRY_OP, rrc_pkg::SEL_X, 1'b1, 4'hF));
      xfer(1'b0, rrc_pkg::ADDR_STAT, 32'h0);
      chk({28'h0, rd[3:0]}, 32'h0000000A, "stat busy");
      wr32(rrc_pkg::ADDR_ACC_X, 32'h00FFFFFF);
      wait_idle;
      m = rot_model(24'h000F0F, 4'h0, 15);
      rd_chk(rrc_pkg::ADDR_ACC_X, {8'h00, m[23:0]}, "write while busy");
      $display("test busy refusal done");
      for (int k = 0; k < 3; k++) begin
         wr32(rrc_pkg::ADDR_DIV, k == 2 ? 32'h3 : 32'hA);
         wr32(rrc_pkg::ADDR_ACC_X, k == 0 ? 32'd44 : (k == 1 ? 32'd45 : 32'd8));
         wr32(rrc_pkg::ADDR_CMD, cmd(rrc_pkg::OP_ROUND, rrc_pkg::SEL_X, 1'b0, 4'h0));
         wait_idle;
         rd_chk(rrc_pkg::ADDR_ACC_X, k == 0 ? 32'd4 : (k == 1 ? 32'd5 : 32'd3), "round");
         chk(instr_len, rrc_pkg::LEN_ROUND, "round len");
      end
      $display("test round done");
      wr32(rrc_pkg::ADDR_FLAGS, 32'hE);
      wr32(rrc_pkg::ADDR_CMD, cmd(rrc_pkg::OP_FORCE_CARRY_OP, rrc_pkg::SEL_Y, 1'b0, 4'h0));
      wait_idle;
      chk(n, 0, "force_carry_op cycles");
      rd_chk(rrc_pkg::ADDR_FLAGS, 32'hD, "force_carry_op flags");
      chk(instr_len, rrc_pkg::LEN_FORCE_CARRY_OP, "force_carry_op len");
      rd_chk(8'h20, 32'h0, "unmapped");
      $display("test force_carry_op done");
      wr32(rrc_pkg::ADDR_ACC_Y, 32'h5);
      wr32(rrc_pkg::ADDR_CMD, cmd(rrc_pkg::OP_ROTATE_RIGHT_CARRY_OP, rrc_pkg::SEL_Y, 1'b1, 4'hF));
      @(posedge mclk);
      rst_n <= 1'b0;
      @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      chk({28'h0, busy, instr_len}, 32'h0, "mid reset");
      rd_chk(rrc_pkg::ADDR_ACC_Y, 32'h0, "acc after reset");
      $display("test mid reset done");
      tally_and_finish;
   end
endmodule
